// *** verilog/hpp_map.vh ***
// Constants of the hub port power and configuration block.
// Assumes a 10 MHz system clock and Avalon-MM byte addressing of 32-bit registers.
`ifndef HPP_MAP_VH
`define HPP_MAP_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define HPP_CLK_KHZ        10000
`define HPP_OC_SAMPLE_MS   2

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define HPP_REG_CTRL       4'h0
`define HPP_REG_STATUS     4'h4
`define HPP_REG_INT_STAT   4'h8
`define HPP_REG_INT_MASK   4'hc

// ----------------------------------------
// Reset values
// ----------------------------------------
`define HPP_CTRL_RST       3'h0
`define HPP_MASK_RST       4'h0

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define HPP_ST_THREE       0
`define HPP_ST_GANG        1
`define HPP_ST_FIXED_LO    2
`define HPP_ST_BYPASS      4
`define HPP_ST_SUSP        5
`define HPP_ST_OC_LO       8
`define HPP_ST_PWR_LO      12

// ----------------------------------------
// Interrupt bit positions
// ----------------------------------------
`define HPP_INT_OC_LO      0
`define HPP_INT_SUSP       3

`endif

// *** verilog/hpp_port_power.v ***
// Port power, overcurrent filter, straps and clock select of the hub.
// Assumes straps and overcurrent pins are asynchronous board levels and
// that the hub engine drives suspend_request on the same clock.
//
// Contract
// [R1] Per-port mode: each overcurrent_n input belongs to its own port only.
// [R2] Ganged mode: overcurrent on any input applies to every port.
// [R3] Each overcurrent_n input is sampled once every 2 ms.
// [R4] Only two consecutive asserted samples pass; a single one is ignored.
// [R5] Port three overcurrent input gets a pull-up enable in 2-port mode.
// [R6] port_power_on_n are active-low push-pull, driven at both levels.
// [R7] While reset is low all logic holds its initial state.
// [R8] The system asserts reset at power-up, ideally 100 us to 1 ms.
// [R9] The chosen clock runs for the last 60 us of reset.
// [R10] suspend_status is high in suspend, low in normal operation.
// [R11] Mode strap low: core clocked from the multiplier on the 6 MHz input.
// [R12] Mode strap high: multiplier bypassed, 48 MHz input drives core.
// [R13] Crystal mode derives both 48 MHz and 12 MHz core clocks.
// [R14] three_port_select_n low gives three ports, high gives two.
// [R15] fixed_port_count straps tell how many ports are permanently attached.
// [R16] With memory disabled, gang strap picks ganged or per-port detection.
// [R17] fixed_port_count is binary, clamped to the configured port count.
// [R18] Filtered overcurrent removes power from affected ports and flags it.
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`include "hpp_map.vh"

module hpp_port_power #(
    parameter SAMPLE_CYCLES = `HPP_OC_SAMPLE_MS * `HPP_CLK_KHZ
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire [2:0]  overcurrent_n,
    output reg  [2:0]  port_power_on_n,
    output wire        overcurrent3_pullup_en,
    input  wire        suspend_request,
    output reg         suspend_status,
    input  wire        mode_strap,
    output wire        internal_clock_multiplier_en,
    output wire        core_clock_bypass,
    output wire        crystal_drive_en,
    input  wire        three_port_select_n,
    input  wire [1:0]  fixed_port_count,
    input  wire        external_memory_enable_n,
    input  wire        serial_data_or_gang_select,
    output wire [1:0]  fixed_ports,
    output wire        irq
);

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
// Bits: oc[2:0], mode, np3_n, fixed[1:0], external_memory_enable_n_n, gang
reg  [8:0] pin_meta;
reg  [8:0] pin_sync;
wire [8:0] pin_raw;

assign pin_raw = {serial_data_or_gang_select, external_memory_enable_n,
                  fixed_port_count, three_port_select_n, mode_strap,
                  overcurrent_n};

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        pin_meta <= 9'h1ff;
        pin_sync <= 9'h1ff;
    end else begin
        pin_meta <= pin_raw;
        pin_sync <= pin_meta;
    end
end

// ----------------------------------------
// Strap capture
// ----------------------------------------
// Straps are static by contract; caught once, three cycles after release
// so the synchroniser has settled.
reg        strap_done;
reg [1:0]  strap_wait;
reg        strap_mode;
reg        strap_np3_n;
reg [1:0]  strap_fixed;
reg        strap_gang;

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin                                  // see [R7]
        strap_done  <= 1'b0;
        strap_wait  <= 2'h0;
        strap_mode  <= 1'b0;
        strap_np3_n <= 1'b0;
        strap_fixed <= 2'h0;
        strap_gang  <= 1'b0;
    end else if (!strap_done) begin
        strap_wait <= strap_wait + 2'h1;
        if (strap_wait == 2'h2) begin
            strap_done  <= 1'b1;
            strap_mode  <= pin_sync[3];
            strap_np3_n <= pin_sync[4];
            strap_fixed <= pin_sync[6:5];
            // Gang strap only means gang while memory is disabled
            strap_gang  <= pin_sync[7] & pin_sync[8];  // see [R16]
        end
    end
end

// ----------------------------------------
// Strap decode
// ----------------------------------------
wire       three_ports;
wire [2:0] port_present;
wire [1:0] port_limit;
reg  [1:0] fixed_clamp;

assign three_ports  = ~strap_np3_n;                    // see [R14]
assign port_present = {three_ports, 2'h3};
assign port_limit   = three_ports ? 2'h3 : 2'h2;       // see [R14]

// Binary count, clamped so the hub never reports more attached ports
// than it has.
always @* begin
    if (strap_fixed > port_limit) begin
        fixed_clamp = port_limit;                      // see [R17]
    end else begin
        fixed_clamp = strap_fixed;                     // see [R15]
    end
end

// ----------------------------------------
// Clock source select and registered configuration
// ----------------------------------------
// The core clock mux itself sits in the analog wrapper; these steer it.
// Held at the crystal setting in reset so the multiplier starts early.
reg        cfg_mult_en;
reg        cfg_bypass;
reg        cfg_xtal_en;
reg        cfg_pullup;
reg  [1:0] cfg_fixed;

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin                                  // see [R7]
        cfg_mult_en <= 1'b1;
        cfg_bypass  <= 1'b0;
        cfg_xtal_en <= 1'b1;
        cfg_pullup  <= 1'b0;
        cfg_fixed   <= 2'h0;
    end else begin
        cfg_mult_en <= ~strap_mode;                    // see [R11] [R13]
        cfg_bypass  <= strap_mode;                     // see [R12]
        cfg_xtal_en <= ~strap_mode;                    // see [R11]
        // Keeps a floating third input inactive on a two-port board
        cfg_pullup  <= ~three_ports;                   // see [R5]
        cfg_fixed   <= fixed_clamp;                    // see [R15] [R17]
    end
end

assign internal_clock_multiplier_en = cfg_mult_en;
assign core_clock_bypass            = cfg_bypass;
assign crystal_drive_en             = cfg_xtal_en;
assign overcurrent3_pullup_en       = cfg_pullup;
assign fixed_ports                  = cfg_fixed;

// ----------------------------------------
// Overcurrent sample tick
// ----------------------------------------
reg  [14:0] tick_cnt;
reg         tick;

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        tick_cnt <= 15'h0;
        tick     <= 1'b0;
    end else if (tick_cnt == SAMPLE_CYCLES - 1) begin
        tick_cnt <= 15'h0;
        tick     <= 1'b1;                              // see [R3]
    end else begin
        tick_cnt <= tick_cnt + 15'h1;
        tick     <= 1'b0;
    end
end

// ----------------------------------------
// Two-sample filter per port
// ----------------------------------------
// A level change passes only when two samples agree, so spikes shorter
// than one period never reach the power logic.
reg  [2:0] oc_prev;
reg  [2:0] oc_filt;
wire [2:0] oc_rise;

genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_filt
        // An absent port always samples as fault free
        wire oc_sample;
        assign oc_sample = ~pin_sync[gi] & port_present[gi];
        always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                oc_prev[gi] <= 1'b0;
                oc_filt[gi] <= 1'b0;
            end else if (tick) begin                   // see [R3]
                oc_prev[gi] <= oc_sample;
                if (oc_prev[gi] == oc_sample) begin
                    oc_filt[gi] <= oc_prev[gi];        // see [R4]
                end
            end
        end
    end
endgenerate

// Ganged: any filtered input hits all ports; else each its own
wire [2:0] oc_eff;
assign oc_eff = strap_gang ? {3{|oc_filt}} & port_present
                           : oc_filt;                  // see [R1] [R2]

reg  [2:0] oc_eff_d;
assign oc_rise = oc_eff & ~oc_eff_d;

// ----------------------------------------
// Port power and suspend
// ----------------------------------------
reg  [2:0] power_req;
wire [2:0] next_power_on;

assign next_power_on = power_req & port_present & ~oc_eff; // see [R18]

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        port_power_on_n <= 3'h7;                       // see [R6]
        oc_eff_d        <= 3'h0;
    end else begin
        port_power_on_n <= ~next_power_on;             // see [R6] [R18]
        oc_eff_d        <= oc_eff;
    end
end

// ----------------------------------------
// Suspend status
// ----------------------------------------
// Follows the hub engine one cycle late; entry is also an event.
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        suspend_status <= 1'b0;                        // see [R7]
    end else begin
        suspend_status <= suspend_request;             // see [R10]
    end
end

wire susp_rise;
assign susp_rise = suspend_request & ~suspend_status;

// ----------------------------------------
// Avalon-MM slave
// ----------------------------------------
// One wait state on every access; readdata is loaded with the answer.
reg        ack;
wire       req;
wire       wr_take;
reg  [3:0] int_stat;
reg  [3:0] int_mask;
wire [3:0] int_set;
wire [3:0] int_clr;
reg [31:0] rd_mux;

wire       wr_ctrl;
wire       wr_mask;
wire       wr_istat;

assign req             = avs_read | avs_write;
assign avs_waitrequest = req & ~ack;
assign wr_take         = avs_write & ack;
assign wr_ctrl         = wr_take && (avs_address == `HPP_REG_CTRL);
assign wr_mask         = wr_take && (avs_address == `HPP_REG_INT_MASK);
assign wr_istat        = wr_take && (avs_address == `HPP_REG_INT_STAT);

always @* begin
    rd_mux = 32'h0;
    case (avs_address)
        `HPP_REG_CTRL:     rd_mux[2:0] = power_req;
        `HPP_REG_STATUS: begin
            rd_mux[`HPP_ST_THREE]          = three_ports;
            rd_mux[`HPP_ST_GANG]           = strap_gang;
            rd_mux[`HPP_ST_FIXED_LO +: 2]  = fixed_ports;
            rd_mux[`HPP_ST_BYPASS]         = strap_mode;
            rd_mux[`HPP_ST_SUSP]           = suspend_status;
            rd_mux[`HPP_ST_OC_LO +: 3]     = oc_eff;
            rd_mux[`HPP_ST_PWR_LO +: 3]    = ~port_power_on_n;
        end
        `HPP_REG_INT_STAT: rd_mux[3:0] = int_stat;
        `HPP_REG_INT_MASK: rd_mux[3:0] = int_mask;
        default:           rd_mux = 32'h0;
    endcase
end

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        ack          <= 1'b0;
        avs_readdata <= 32'h0;
        power_req    <= `HPP_CTRL_RST;
        int_mask     <= `HPP_MASK_RST;
    end else begin
        ack <= req & ~ack;
        if (avs_read & ~ack)
            avs_readdata <= rd_mux;
        if (wr_ctrl) begin
            power_req <= avs_writedata[2:0];
        end
        if (wr_mask) begin
            int_mask <= avs_writedata[3:0];
        end
    end
end

// ----------------------------------------
// Interrupts
// ----------------------------------------
// Set wins over a write-one-to-clear in the same cycle.
assign int_set = {susp_rise, oc_rise};                 // see [R18]
assign int_clr = wr_istat ? avs_writedata[3:0] : 4'h0;

genvar ii;
generate
    for (ii = 0; ii < 4; ii = ii + 1) begin : g_int
        always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                int_stat[ii] <= 1'b0;
            end else if (int_set[ii]) begin
                int_stat[ii] <= 1'b1;                  // see [R18]
            end else if (int_clr[ii]) begin
                int_stat[ii] <= 1'b0;
            end
        end
    end
endgenerate

assign irq = |(int_stat & int_mask);

endmodule // hpp_port_power

// *** tb/hpp_board_model.sv ***
// Board beside the hub: gang wiring and power switch fault pins.
// Assumes the bench sets faults and straps just after clock edges.
module hpp_board_model (
    input  wire logic       clk,
    input  wire logic       gang,
    input  wire logic       two_port,
    input  wire logic [2:0] fault,
    input  wire logic       overcurrent3_pullup_en,
    output logic      [2:0] overcurrent_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic toggle = 1'b0;
    always @(posedge clk) toggle <= ~toggle;
    always_comb begin
        overcurrent_n = ~fault;
        if (gang) overcurrent_n = {3{~|fault}};
        // Unwired third pin floats unless pulled up
        if (two_port)
            overcurrent_n[2] = overcurrent3_pullup_en | toggle;
    end
endmodule // hpp_board_model

// *** tb/hpp_checker.sv ***
// Timing checks on the hub port power block ports.
// Assumes one clock and the asynchronous low reset.
module hpp_checker (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [2:0]  port_power_on_n,
    input wire logic        suspend_request,
    input wire logic        suspend_status,
    input wire logic        irq,
    input wire logic        core_clock_bypass,
    input wire logic        internal_clock_multiplier_en,
    input wire logic        overcurrent3_pullup_en,
    input wire logic [1:0]  fixed_ports
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_rst;
        $rose(rst_n) |-> port_power_on_n == 3'h7 && !suspend_status && !irq;
    endproperty
    a_rst: assert property (p_rst)
        else $error("outputs not idle at reset release");
    property p_susp;
        1 |=> suspend_status == $past(suspend_request);
    endproperty
    a_susp: assert property (p_susp)
        else $error("suspend status wrong");
    property p_wait1;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait1: assert property (p_wait1)
        else $error("more than one wait state");
    property p_wait_first;
        $rose(avs_read || avs_write) |-> avs_waitrequest;
    endproperty
    a_wait_first: assert property (p_wait_first)
        else $error("no wait state");
    property p_wait_idle;
        !(avs_read || avs_write) |-> !avs_waitrequest;
    endproperty
    a_wait_idle: assert property (p_wait_idle)
        else $error("waitrequest while idle");
    property p_clk_sel;
        core_clock_bypass != internal_clock_multiplier_en;
    endproperty
    a_clk_sel: assert property (p_clk_sel)
        else $error("clock select inconsistent");
    property p_fixed;
        overcurrent3_pullup_en |-> fixed_ports <= 2'h2;
    endproperty
    a_fixed: assert property (p_fixed)
        else $error("fixed ports over port count");
    property p_unmapped;
        avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
            |-> avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    c_susp: cover property ($rose(suspend_status));
    c_irq: cover property ($rose(irq));
    c_off: cover property ($rose(port_power_on_n[1]));
endmodule // hpp_checker

bind hpp_port_power hpp_checker i_hpp_checker (.*);

// *** tb/tb_hub_port_power_config.sv ***
// Bench for the hub port power block: bus, straps, faults, suspend.
// Assumes one wait state per access and a short filter tick.
module tb_hub_port_power_config;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int S = 20;
    logic clk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [2:0] overcurrent_n, port_power_on_n, fault;
    logic overcurrent3_pullup_en, suspend_request, suspend_status;
    logic mode_strap, internal_clock_multiplier_en, core_clock_bypass;
    logic crystal_drive_en, three_port_select_n, external_memory_enable_n;
    logic serial_data_or_gang_select;
    logic [1:0] fixed_port_count, fixed_ports, fp;
    logic [31:0] exp_q[$], msk_q[$];
    int fail_count = 0;
    int check_count = 0;
    hpp_port_power #(.SAMPLE_CYCLES(S)) i_hpp_port_power (.*);
    hpp_board_model i_hpp_board_model (.clk(clk),
        .gang(serial_data_or_gang_select), .two_port(three_port_select_n),
        .fault(fault), .overcurrent3_pullup_en(overcurrent3_pullup_en),
        .overcurrent_n(overcurrent_n));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // Reads note their expectation; the watcher below compares
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, input logic [31:0] m = '1);
        int n;
        n = 0;
        if (!w) exp_q.push_back(d & m);
        if (!w) msk_q.push_back(m);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) chk("waitrequest", 0, 1);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    always @(posedge clk)
        if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
            chk("readdata", exp_q.pop_front(), avs_readdata & msk_q.pop_front());
    task automatic reset_with(input logic np, gang, mode, input logic [1:0] f);
        rst_n <= 1'b0;
        three_port_select_n <= np;
        serial_data_or_gang_select <= gang;
        mode_strap <= mode;
        fixed_port_count <= f;
        repeat (16) @(posedge clk);
        chk("power", 7, port_power_on_n);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        print_verdict();
    end
    initial begin
        {rst_n, avs_read, avs_write, suspend_request} = 4'h0;
        {avs_address, avs_writedata, fault} = '0;
        {mode_strap, three_port_select_n, fixed_port_count} = 4'h0;
        {external_memory_enable_n, serial_data_or_gang_select} = 2'h2;
        void'($urandom(32'h019f7eee));
        fp = 2'($urandom_range(3));
        reset_with(1'b0, 1'b0, 1'b1, fp);
        chk("bypass", 1, core_clock_bypass);
        chk("crystal", 0, crystal_drive_en);
        chk("fixed", fp, fixed_ports);
        bus(0, 4'h4, {27'h1, fp, 2'h1}, 32'h1f);
        bus(0, 4'h2, 32'h0);
        bus(1, 4'hc, 32'hf);
        bus(1, 4'h0, 32'h7);
        repeat (2) @(posedge clk);
        chk("power", 0, port_power_on_n);
        fault <= 3'h1;
        repeat (S / 2) @(posedge clk);
        fault <= 3'h0;
        repeat (3 * S) @(posedge clk);
        chk("power", 0, port_power_on_n);
        fault <= 3'h2;
        repeat (3 * S + 5) @(posedge clk);
        chk("power", 2, port_power_on_n);
        chk("irq", 1, irq);
        bus(0, 4'h8, 32'h2, 32'hf);
        fault <= 3'h0;
        repeat (3 * S + 5) @(posedge clk);
        bus(1, 4'h8, 32'hf);
        bus(0, 4'h8, 32'h0, 32'hf);
        chk("power", 0, port_power_on_n);
        suspend_request <= 1'b1;
        repeat (3) @(posedge clk);
        chk("suspend", 1, suspend_status);
        chk("irq", 1, irq);
        suspend_request <= 1'b0;
        repeat (3) @(posedge clk);
        chk("suspend", 0, suspend_status);
        reset_with(1'b1, 1'b1, 1'b0, 2'h3);
        chk("pullup", 1, overcurrent3_pullup_en);
        chk("multiplier", 1, internal_clock_multiplier_en);
        chk("crystal", 1, crystal_drive_en);
        chk("fixed", 2, fixed_ports);
        bus(0, 4'h4, 32'ha, 32'h1f);
        bus(1, 4'h0, 32'h7);
        fault <= 3'h1;
        repeat (3 * S + 5) @(posedge clk);
        chk("power", 7, port_power_on_n);
        print_verdict();
    end
endmodule // tb_hub_port_power_config
